//--- src/eep_pkg.sv
// Constants shared by the two-wire EEPROM slave front end and its storage.
// Assumes a single core clock at EEP_CLK_HZ; all bus pins arrive asynchronously.
package eep_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int EEP_CLK_HZ        = 25_000_000;
    localparam int EEP_WRITE_TIME_MS = 5;
    // Longest time: rounded down to whole cycles
    localparam int EEP_WRITE_CYCLES  = (EEP_WRITE_TIME_MS * (EEP_CLK_HZ / 1000));

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int EEP_MEM_BYTES  = 4096;
    localparam int EEP_ADDR_W     = 12;
    localparam int EEP_PAGE_BYTES = 32;
    localparam int EEP_PAGE_W     = 5;

    // ------------------------------------------------------------------
    // Byte positions within a write transfer
    // ------------------------------------------------------------------
    localparam logic [1:0] EEP_IDX_DEV  = 2'h0;
    localparam logic [1:0] EEP_IDX_HI   = 2'h1;
    localparam logic [1:0] EEP_IDX_LO   = 2'h2;
    localparam logic [1:0] EEP_IDX_DATA = 2'h3;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int EEP_TYPE_MSB  = 7;
    localparam int EEP_TYPE_LSB  = 4;
    localparam int EEP_SEL_MSB   = 3;
    localparam int EEP_SEL_LSB   = 1;
    localparam int EEP_RW_BIT    = 0;
    localparam int EEP_LAST_BIT  = 7;
    localparam logic [EEP_ADDR_W-1:0] EEP_ADDR_RST = 12'h000;
    localparam logic [7:0]            EEP_SR_RST   = 8'h00;

    typedef enum logic [3:0] {
        EEP_ST_IDLE,
        EEP_ST_RX,
        EEP_ST_ACK1,
        EEP_ST_ACK2,
        EEP_ST_TX,
        EEP_ST_MACK,
        EEP_ST_TXLD,
        EEP_ST_WRITE
    } eep_state_t;

endpackage

//--- src/eep_mem.sv
// Byte-wide storage array with one write port and a registered read port.
// Assumes writes and reads share the core clock; contents are undefined at power-up.
module eep_mem
    import eep_pkg::*;
#(
    parameter int DEPTH = EEP_MEM_BYTES,
    parameter int AW    = EEP_ADDR_W
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // eep_mem

//--- src/eep_bus_slave.sv
// Two-wire bus slave front end of a 4096-byte serial EEPROM with page writes.
// Assumes SCL, SDA, straps and write-protect are asynchronous pins, oversampled by core_clk.
//
// Summary of operation
// RQ1: Sample on SCL rise, change after fall.
// RQ2: Data line driven low only, else released.
// RQ3: Data changes only while SCL is low.
// RQ4: SDA fall with SCL high starts transfer.
// RQ5: Stop after read returns to standby.
// RQ6: Stop after write data starts timed write.
// RQ7: Ignore bus while write cycle runs.
// RQ8: Bytes MSB first, acknowledged on ninth clock.
// RQ9: Transmitter releases line on ninth clock.
// RQ10: Acknowledge every byte of allowed write.
// RQ11: Master ack zero fetches next address byte.
// RQ12: Master nak then stop ends read.
// RQ13: No ack or stop: stay released.
// RQ14: Address word: type, select 2..0, direction.
// RQ15: Match acks; direction picks read or write.
// RQ16: Mismatch goes standby, ignores transfer.
// RQ17: Write takes two acknowledged address bytes.
// RQ18: Further bytes buffered, up to 32.
// RQ19: Page offset increments, wraps within page.
// RQ20: Protect pin high: nak first data byte.
// RQ21: Protect covers whole array; reads unaffected.
// RQ22: No ack for write word while busy.
// RQ23: Address counter holds last address plus one.
// RQ24: Master sets read address by dummy write.
// RQ25: Sequential read wraps from top to zero.
// RQ26: First address byte is upper part.
module eep_bus_slave
    import eep_pkg::*;
#(
    parameter int         WRITE_CYCLES = EEP_WRITE_CYCLES,
    // Device-type code: value is arbitrary
    parameter logic [3:0] DEV_TYPE     = 4'h6
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic select_strap_bit0,
    input  wire logic select_strap_bit1,
    input  wire logic select_strap_bit2,
    input  wire logic write_protect,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      write_busy
);

    localparam int TW = $clog2(WRITE_CYCLES + 1);

    // ------------------------------------------------------------------
    // Pin synchronisers and bus condition detection
    // ------------------------------------------------------------------
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       scl_s;
    logic       sda_s;
    logic [2:0] strap_s;
    logic       wp_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync1_q <= 6'h03;
            sync2_q <= 6'h03;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            sync1_q <= {write_protect, select_strap_bit2, select_strap_bit1,
                        select_strap_bit0, sda_in, scl_in};
            sync2_q <= sync1_q;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_s      = sync2_q[0];
    assign sda_s      = sync2_q[1];
    assign strap_s    = sync2_q[4:2];
    assign wp_s       = sync2_q[5];
    assign scl_rise   = scl_s & ~scl_p_q;                         // RQ1
    assign scl_fall   = ~scl_s & scl_p_q;                         // RQ1
    // Both SCL samples high: a data edge here is a condition, not data
    assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;       // RQ4
    assign stop_cond  = scl_s & scl_p_q & ~sda_p_q & sda_s;       // RQ5

    // ------------------------------------------------------------------
    // State and datapath registers
    // ------------------------------------------------------------------
    eep_state_t                     state_q;
    eep_state_t                     state_d;
    logic [2:0]                     bit_cnt_q;
    logic [2:0]                     bit_cnt_d;
    logic [1:0]                     byte_idx_q;
    logic [1:0]                     byte_idx_d;
    logic [7:0]                     rx_sr_q;
    logic [7:0]                     rx_sr_d;
    logic [7:0]                     tx_sr_q;
    logic [7:0]                     tx_sr_d;
    logic                           is_read_q;
    logic                           is_read_d;
    logic                           ack_ok_q;
    logic                           ack_ok_d;
    logic [EEP_ADDR_W-1:0]          addr_q;
    logic [EEP_ADDR_W-1:0]          addr_d;
    logic [3:0]                     addr_hi_q;
    logic [3:0]                     addr_hi_d;
    logic                           pend_q;
    logic                           pend_d;
    logic [EEP_PAGE_BYTES-1:0]      mask_q;
    logic [EEP_PAGE_BYTES-1:0]      mask_d;
    logic                           oe_q;
    logic                           oe_d;
    logic [TW-1:0]                  timer_q;
    logic [TW-1:0]                  timer_d;
    logic [EEP_PAGE_W:0]            commit_q;
    logic [EEP_PAGE_W:0]            commit_d;
    logic                           busy_q;
    logic                           sda_o_q;
    logic [7:0]                     rx_byte;
    logic                           dev_match;
    logic                           buf_we;
    logic                           commit_live;
    logic                           mem_we;
    logic [EEP_ADDR_W-1:0]          mem_waddr;
    logic [7:0]                     rd_data;
    logic [7:0]                     page_buf [EEP_PAGE_BYTES];

    assign rx_byte   = {rx_sr_q[6:0], sda_s};                     // RQ8
    assign dev_match = (rx_byte[EEP_TYPE_MSB:EEP_TYPE_LSB] == DEV_TYPE)
                     && (rx_byte[EEP_SEL_MSB:EEP_SEL_LSB] == strap_s); // RQ14

    // Commit one buffered page slot per cycle at the start of the write cycle
    assign commit_live = (state_q == EEP_ST_WRITE) && !commit_q[EEP_PAGE_W];
    assign mem_we      = commit_live && mask_q[commit_q[EEP_PAGE_W-1:0]]; // RQ6
    assign mem_waddr   = {addr_q[EEP_ADDR_W-1:EEP_PAGE_W], commit_q[EEP_PAGE_W-1:0]};

    // ------------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        bit_cnt_d  = bit_cnt_q;
        byte_idx_d = byte_idx_q;
        rx_sr_d    = rx_sr_q;
        tx_sr_d    = tx_sr_q;
        is_read_d  = is_read_q;
        ack_ok_d   = ack_ok_q;
        addr_d     = addr_q;
        addr_hi_d  = addr_hi_q;
        pend_d     = pend_q;
        mask_d     = mask_q;
        oe_d       = oe_q;
        timer_d    = timer_q;
        commit_d   = commit_q;
        buf_we     = 1'b0;
        if (state_q == EEP_ST_WRITE) begin
            // Bus is deaf here, so a write-direction word is never acknowledged
            timer_d = timer_q + 1'b1;                                 // RQ7 RQ22
            if (commit_live) begin
                commit_d = commit_q + 1'b1;
            end
            if (timer_q == TW'(WRITE_CYCLES - 1)) begin
                state_d = EEP_ST_IDLE;                                // RQ6
                pend_d  = 1'b0;
            end
        end else if (start_cond) begin
            state_d    = EEP_ST_RX;                                   // RQ4
            bit_cnt_d  = 3'h0;
            byte_idx_d = EEP_IDX_DEV;
            oe_d       = 1'b0;
        end else if (stop_cond) begin
            oe_d = 1'b0;
            if (pend_q) begin
                state_d  = EEP_ST_WRITE;                              // RQ6
                timer_d  = '0;
                commit_d = '0;
            end else begin
                state_d = EEP_ST_IDLE;                                // RQ5 RQ12
            end
        end else begin
            unique case (state_q)
                EEP_ST_RX: begin
                    if (scl_rise) begin
                        rx_sr_d   = rx_byte;
                        bit_cnt_d = bit_cnt_q + 1'b1;
                        if (bit_cnt_q == 3'(EEP_LAST_BIT)) begin
                            state_d  = EEP_ST_ACK1;
                            ack_ok_d = 1'b1;                          // RQ10 RQ17
                            if (byte_idx_q != EEP_IDX_DATA) begin
                                byte_idx_d = byte_idx_q + 1'b1;
                            end
                            unique case (byte_idx_q)
                                EEP_IDX_DEV: begin
                                    ack_ok_d  = dev_match;            // RQ15 RQ16
                                    is_read_d = rx_byte[EEP_RW_BIT];
                                end
                                EEP_IDX_HI: begin
                                    addr_hi_d = rx_byte[3:0];         // RQ26
                                end
                                EEP_IDX_LO: begin
                                    addr_d = {addr_hi_q, rx_byte};    // RQ24 RQ26
                                    mask_d = '0;
                                end
                                EEP_IDX_DATA: begin
                                    if (wp_s) begin
                                        ack_ok_d = 1'b0;              // RQ20 RQ21
                                    end else begin
                                        buf_we = 1'b1;                // RQ18
                                        mask_d[addr_q[EEP_PAGE_W-1:0]] = 1'b1;
                                        pend_d = 1'b1;
                                        addr_d = {addr_q[EEP_ADDR_W-1:EEP_PAGE_W],
                                                  addr_q[EEP_PAGE_W-1:0] + 1'b1}; // RQ19 RQ23
                                    end
                                end
                            endcase
                        end
                    end
                end
                EEP_ST_ACK1: begin
                    if (scl_fall) begin
                        oe_d    = ack_ok_q;                           // RQ2 RQ8
                        state_d = ack_ok_q ? EEP_ST_ACK2 : EEP_ST_IDLE; // RQ16
                    end
                end
                EEP_ST_ACK2: begin
                    if (scl_fall) begin
                        bit_cnt_d = 3'h0;
                        if (is_read_q) begin
                            tx_sr_d = rd_data;                        // RQ15
                            oe_d    = ~rd_data[EEP_LAST_BIT];         // RQ3
                            state_d = EEP_ST_TX;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = EEP_ST_RX;
                        end
                    end
                end
                EEP_ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 3'(EEP_LAST_BIT)) begin
                            oe_d    = 1'b0;                           // RQ9 RQ11
                            state_d = EEP_ST_MACK;
                        end else begin
                            oe_d      = ~tx_sr_q[EEP_LAST_BIT-1];     // RQ1 RQ8
                            tx_sr_d   = {tx_sr_q[6:0], 1'b0};
                            bit_cnt_d = bit_cnt_q + 1'b1;
                        end
                    end
                end
                EEP_ST_MACK: begin
                    if (scl_rise) begin
                        // Wraps to zero past the top of the array
                        addr_d  = addr_q + 1'b1;                      // RQ23 RQ25
                        // Nak parks released until start or stop
                        state_d = sda_s ? EEP_ST_IDLE : EEP_ST_TXLD;  // RQ11 RQ13
                    end
                end
                EEP_ST_TXLD: begin
                    if (scl_fall) begin
                        tx_sr_d   = rd_data;                          // RQ11
                        oe_d      = ~rd_data[EEP_LAST_BIT];
                        bit_cnt_d = 3'h0;
                        state_d   = EEP_ST_TX;
                    end
                end
                EEP_ST_IDLE: begin
                end
                EEP_ST_WRITE: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q    <= EEP_ST_IDLE;
            bit_cnt_q  <= 3'h0;
            byte_idx_q <= EEP_IDX_DEV;
            rx_sr_q    <= EEP_SR_RST;
            tx_sr_q    <= EEP_SR_RST;
            is_read_q  <= 1'b0;
            ack_ok_q   <= 1'b0;
            addr_q     <= EEP_ADDR_RST;
            addr_hi_q  <= 4'h0;
            pend_q     <= 1'b0;
            mask_q     <= '0;
            oe_q       <= 1'b0;
            timer_q    <= '0;
            commit_q   <= '0;
        end else begin
            state_q    <= state_d;
            bit_cnt_q  <= bit_cnt_d;
            byte_idx_q <= byte_idx_d;
            rx_sr_q    <= rx_sr_d;
            tx_sr_q    <= tx_sr_d;
            is_read_q  <= is_read_d;
            ack_ok_q   <= ack_ok_d;
            addr_q     <= addr_d;
            addr_hi_q  <= addr_hi_d;
            pend_q     <= pend_d;
            mask_q     <= mask_d;
            oe_q       <= oe_d;
            timer_q    <= timer_d;
            commit_q   <= commit_d;
        end
    end

    // Output flops; the pad only ever pulls low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy_q  <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            busy_q  <= (state_d == EEP_ST_WRITE);
            sda_o_q <= 1'b0;                                          // RQ2
        end
    end

    assign sda_out    = sda_o_q;
    assign sda_oe     = oe_q;
    assign write_busy = busy_q;

    // ------------------------------------------------------------------
    // Page buffer and array
    // ------------------------------------------------------------------
    // Later bytes at the same offset simply overwrite earlier ones
    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            page_buf[addr_q[EEP_PAGE_W-1:0]] <= rx_byte;              // RQ19
        end
    end

    eep_mem #(
        .DEPTH (EEP_MEM_BYTES),
        .AW    (EEP_ADDR_W)
    ) u_mem (
        .core_clk (core_clk),
        .wr_en    (mem_we),
        .wr_addr  (mem_waddr),
        .wr_data  (page_buf[commit_q[EEP_PAGE_W-1:0]]),
        .rd_addr  (addr_q),
        .rd_data  (rd_data)
    );

endmodule // eep_bus_slave

//--- testbench/eep_master_model.sv
// Behavioural two-wire bus master that drives SCL and pulls SDA low when needed.
// Assumes the bench resolves the SDA wire with a pull-up and feeds it back here.
module eep_master_model (
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_rel
);
    timeunit 1ns;
    timeprecision 100ps;
    // SCL stands high between frames; high 2 cycles, low 6 cycles per bit
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic start;
        sda_rel = 1'b1;
        w(2);
        scl = 1'b1;
        w(2);
        sda_rel = 1'b0;
        w(2);
        scl = 1'b0;
        w(4);
    endtask
    task automatic stop;
        sda_rel = 1'b0;
        w(2);
        scl = 1'b1;
        w(2);
        sda_rel = 1'b1;
        w(4);
    endtask
    // Data changes four cycles into the low phase, well clear of the edges
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        w(2);
        scl = 1'b1;
        w(1);
        r = sda_line;
        w(1);
        scl = 1'b0;
        w(4);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic recv(output logic [7:0] d, input logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nak, r);
    endtask
endmodule // eep_master_model

//--- testbench/eep_bus_slave_chk.sv
// Port-level checker for the two-wire EEPROM slave front end.
// Assumes the bench keeps SCL high 2 cycles and low 6 cycles per bit.
module eep_bus_slave_chk #(
    parameter int WRITE_CYCLES = 125000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic select_strap_bit0,
    input wire logic select_strap_bit1,
    input wire logic select_strap_bit2,
    input wire logic write_protect,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    assign busy_cnt_d = write_busy ? busy_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge core_clk) begin
        if (!nrst) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= busy_cnt_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_start;
        scl_in && sda_in ##1 scl_in && !sda_in;
    endsequence
    // Two samples is the whole high phase of a bench bit, so data bits are covered too
    sequence s_quiet_high;
        scl_in ##1 scl_in;
    endsequence
    property p_drive_low; sda_oe |-> !sda_out; endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda driven high");
    property p_change_low;
        $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_change_low: assert property (p_change_low) else $error("sda moved with scl high");
    property p_stable_high; s_quiet_high |-> $stable(sda_oe); endproperty
    a_stable_high: assert property (p_stable_high) else $error("sda moved in high phase");
    property p_busy_quiet; write_busy |-> !sda_oe; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("bus driven while busy");
    property p_busy_len; $fell(write_busy) |-> busy_cnt_q == WRITE_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_bound; write_busy |-> busy_cnt_q < WRITE_CYCLES; endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("write cycle too long");
    property p_busy_stop;
        $rose(write_busy) |-> scl_in && sda_in && !$past(sda_in, 6);
    endproperty
    a_busy_stop: assert property (p_busy_stop) else $error("write cycle without stop");
    property p_start_release; s_start |-> ##[1:6] !sda_oe; endproperty
    a_start_release: assert property (p_start_release) else $error("held after start");
    property p_wp_nowrite; $rose(write_busy) |-> !write_protect; endproperty
    a_wp_nowrite: assert property (p_wp_nowrite) else $error("write while protected");
endmodule // eep_bus_slave_chk

bind eep_bus_slave eep_bus_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
    .select_strap_bit0(select_strap_bit0), .select_strap_bit1(select_strap_bit1),
    .select_strap_bit2(select_strap_bit2), .write_protect(write_protect),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));

//--- testbench/tb_top.sv
// Self-checking bench for the EEPROM bus slave, driven by the master model.
// Assumes an SDA pull-up; straps fixed at 3'h6; short write cycle of WCYC clocks.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         WCYC = 200;
    localparam logic [3:0] DEV  = 4'h6; // Arbitrary device-type code
    localparam logic [2:0] SEL  = 3'h6;
    logic       core_clk;
    logic       nrst;
    logic       write_protect;
    logic       sda_out;
    logic       sda_oe;
    logic       write_busy;
    logic       scl;
    logic       sda_rel;
    wire        sda_line;
    int         bad_count;
    int         n_compared;
    logic [7:0] rbuf [0:63];
    assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
    eep_bus_slave #(.WRITE_CYCLES(WCYC), .DEV_TYPE(DEV)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
        .select_strap_bit0(SEL[0]), .select_strap_bit1(SEL[1]),
        .select_strap_bit2(SEL[2]), .write_protect(write_protect),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
    eep_master_model mdl_u (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
        .sda_rel(sda_rel));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_idle;
        for (int k = 0; write_busy !== 1'b0; k++) begin
            if (k > 2 * WCYC) begin
                bad_count++;
                final_report();
            end
            @(negedge core_clk);
        end
    endtask
    task automatic set_addr(input logic [15:0] a);
        logic ack;
        mdl_u.start();
        mdl_u.send({DEV, SEL, 1'b0}, ack);
        check({7'h0, ack}, 8'h00);
        mdl_u.send(a[15:8], ack);
        check({7'h0, ack}, 8'h00);
        mdl_u.send(a[7:0], ack);
        check({7'h0, ack}, 8'h00);
    endtask
    task automatic wr_page(input logic [15:0] a, input logic [7:0] d0, input int n);
        logic ack;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            mdl_u.send(d0 + 8'(i), ack);
            check({7'h0, ack}, 8'h00);
        end
        mdl_u.stop();
        check({7'h0, write_busy}, 8'h01);
    endtask
    task automatic rd_seq(input logic [15:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        set_addr(a);
        mdl_u.start();
        mdl_u.send({DEV, SEL, 1'b1}, ack);
        check({7'h0, ack}, 8'h00);
        for (int i = 0; i < n; i++) mdl_u.recv(rbuf[i], i == n - 1);
        mdl_u.recv(d, 1'b1);
        check(d, 8'hFF);
        mdl_u.stop();
    endtask
    task automatic sc_mismatch;
        logic       ack;
        logic [7:0] words [0:2];
        words = '{{DEV ^ 4'h1, SEL, 1'b0}, {DEV, 3'h3, 1'b0}, {DEV, SEL ^ 3'h1, 1'b1}};
        for (int i = 0; i < 3; i++) begin
            mdl_u.start();
            mdl_u.send(words[i], ack);
            check({7'h0, ack}, 8'h01);
            mdl_u.send(8'h00, ack);
            check({7'h0, ack}, 8'h01);
            mdl_u.stop();
        end
    endtask
    task automatic sc_page;
        logic ack;
        int   idx;
        // Upper nibble of the first byte is ignored; 33 bytes wrap and overwrite
        wr_page(16'hF35E, 8'hA0, 33);
        mdl_u.start();
        mdl_u.send({DEV, SEL, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        mdl_u.stop();
        check({7'h0, write_busy}, 8'h01);
        wait_idle();
        mdl_u.start();
        mdl_u.send({DEV, SEL, 1'b0}, ack);
        check({7'h0, ack}, 8'h00);
        mdl_u.stop();
        rd_seq(16'h0340, 32);
        for (int o = 0; o < 32; o++) begin
            idx = (o == 30) ? 32 : (o == 31) ? 1 : o + 2;
            check(rbuf[o], 8'hA0 + 8'(idx));
        end
    endtask
    task automatic sc_protect;
        logic ack;
        write_protect = 1'b1;
        mdl_u.w(4);
        set_addr(16'h0340);
        mdl_u.send(8'h55, ack);
        check({7'h0, ack}, 8'h01);
        mdl_u.stop();
        mdl_u.w(4);
        check({7'h0, write_busy}, 8'h00);
        rd_seq(16'h0340, 1);
        check(rbuf[0], 8'hA2);
        write_protect = 1'b0;
        mdl_u.w(4);
    endtask
    task automatic sc_wrap;
        wr_page(16'h0FFF, 8'h3C, 1);
        wait_idle();
        wr_page(16'h0000, 8'hC3, 1);
        wait_idle();
        rd_seq(16'h0FFF, 2);
        check(rbuf[0], 8'h3C);
        check(rbuf[1], 8'hC3);
    endtask
    initial begin
        bad_count = 0;
        n_compared = 0;
        nrst = 1'b0;
        write_protect = 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        mdl_u.w(4);
        sc_mismatch();
        sc_page();
        sc_protect();
        sc_wrap();
        final_report();
    end
endmodule // tb_top
